//--- hdl/stwp_map.svh
/*
 * register offsets, field positions and reset values of the shared divider block.
 * assumes inclusion by bare name from the design files.
 */
`ifndef STWP_MAP_SVH
`define STWP_MAP_SVH

`define STWP_OFF_TIMER_COUNT 8'h01
`define STWP_OFF_INTR_CTRL 8'h0B
`define STWP_OFF_PRESCALE_CFG 8'h81
`define STWP_OFF_PORTA_DIR 8'h85
`define STWP_OFF_CMD 8'h90
`define STWP_OFF_STATUS 8'h91
`define STWP_OFF_WDT_TOP 8'h92

`define STWP_RST_PRESCALE_CFG 8'hFF
`define STWP_RST_PORTA_DIR 8'h1F
`define STWP_RST_INTR_CTRL 8'h00
`define STWP_RST_WDT_TOP 8'hFF
`define STWP_PORTA_DIR_MASK 8'h1F

`define STWP_BIT_ASSIGN 3
`define STWP_BIT_T0_SRC 5
`define STWP_BIT_T0_EDGE 4
`define STWP_BIT_T0_IE 5
`define STWP_BIT_T0_IF 2
`define STWP_BIT_CMD_WDT_CLR 0
`define STWP_BIT_CMD_WDT_EN 1

`endif

//--- hdl/stwp_pkg.sv
/*
 * types of the shared divider block.
 * assumes stwp_map.svh alongside.
 */
package stwp_pkg;
    typedef enum logic [1:0] {
        stwp_bus_idle,
        stwp_bus_ack
    } stwp_bus_state_t;

    typedef enum logic {
        stwp_to_timer,
        stwp_to_watchdog
    } stwp_assign_t;
endpackage

//--- hdl/stwp_divider.sv
/*
 * shared 8-bit divider: counts input ticks, emits one tick per 2^n.
 * assumes clear is a single-cycle pulse on mclk; tick may stay high, counting every cycle.
 */
`include "stwp_map.svh"

module stwp_divider #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // control
    input wire logic tick_in,
    input wire logic clear,
    input wire logic [3:0] log2_ratio,
    // result
    output logic tick_out
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic [WIDTH:0] mask;
    logic wrap;

    assign mask = ({{WIDTH{1'b0}}, 1'b1} << log2_ratio) - {{WIDTH{1'b0}}, 1'b1};
    assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
    assign wrap = tick_in && ((next_count & mask[WIDTH-1:0]) == '0);
    assign tick_out = (log2_ratio == 4'h0) ? tick_in : wrap;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (tick_in) begin
            count <= next_count;
        end
    end
endmodule

//--- hdl/stwp_top.sv
/*
 * timer counter and watchdog sharing one divider, with Avalon-MM slave.
 * assumes tmr_pin arrives asynchronously; bus is synchronous to mclk.
 */
// Local design decision: register access over Avalon-MM.
`include "stwp_map.svh"

module stwp_top #(
    parameter int WDT_TICK_CYCLES = 360
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // pins and events
    input wire logic tmr_pin,
    output logic watchdog_reset,
    output logic timer_overflow
);
    // ********************
    // bus decode
    // ********************
    stwp_pkg::stwp_bus_state_t bus_state;
    logic [7:0] timer_count_value;
    logic [7:0] interrupt_control;
    logic [7:0] timer_prescale_config;
    logic [7:0] port_a_direction;
    logic [7:0] wdt_top;
    logic wdt_enable;
    logic wdt_timeout_seen;
    logic [7:0] wdt_count;
    logic [31:0] next_readdata;
    logic access;
    logic wr_fire;
    logic rd_fire;
    logic wr_tmr;
    logic wr_cfg;
    logic wr_cmd;
    logic [7:0] wdata;

    assign access = avs_read || avs_write;
    assign avs_waitrequest = access && (bus_state != stwp_pkg::stwp_bus_ack);
    assign wr_fire = avs_write && (bus_state == stwp_pkg::stwp_bus_ack);
    assign rd_fire = avs_read && (bus_state == stwp_pkg::stwp_bus_ack);
    assign wdata = avs_writedata[7:0];
    assign wr_tmr = wr_fire && (avs_address == `STWP_OFF_TIMER_COUNT);
    assign wr_cfg = wr_fire && (avs_address == `STWP_OFF_PRESCALE_CFG);
    assign wr_cmd = wr_fire && (avs_address == `STWP_OFF_CMD);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bus_state <= stwp_pkg::stwp_bus_idle;
        end else begin
            case (bus_state)
                stwp_pkg::stwp_bus_idle: begin
                    if (access) begin
                        bus_state <= stwp_pkg::stwp_bus_ack;
                    end
                end
                stwp_pkg::stwp_bus_ack: bus_state <= stwp_pkg::stwp_bus_idle;
                default: bus_state <= stwp_pkg::stwp_bus_idle;
            endcase
        end
    end

    // divider count is absent from this map
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            `STWP_OFF_TIMER_COUNT: next_readdata[7:0] = timer_count_value;
            `STWP_OFF_INTR_CTRL: next_readdata[7:0] = interrupt_control;
            `STWP_OFF_PRESCALE_CFG: next_readdata[7:0] = timer_prescale_config;
            `STWP_OFF_PORTA_DIR: next_readdata[7:0] = port_a_direction;
            `STWP_OFF_CMD: next_readdata[`STWP_BIT_CMD_WDT_EN] = wdt_enable;
            `STWP_OFF_STATUS: next_readdata[7:0] = {7'h00, wdt_timeout_seen};
            `STWP_OFF_WDT_TOP: next_readdata[7:0] = wdt_top;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && bus_state == stwp_pkg::stwp_bus_idle) begin
            avs_readdata <= next_readdata;
        end
    end

    // ********************
    // configuration registers
    // ********************
    logic divider_assign_bit;
    logic [2:0] divide_ratio_field;
    logic t0_edge_sel;
    logic t0_src_pin;
    logic watchdog_clear_instr;

    assign divider_assign_bit = timer_prescale_config[`STWP_BIT_ASSIGN];
    assign divide_ratio_field = timer_prescale_config[2:0];
    assign t0_edge_sel = timer_prescale_config[`STWP_BIT_T0_EDGE];
    assign t0_src_pin = timer_prescale_config[`STWP_BIT_T0_SRC];
    assign watchdog_clear_instr = wr_cmd && wdata[`STWP_BIT_CMD_WDT_CLR];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            timer_prescale_config <= `STWP_RST_PRESCALE_CFG;
            port_a_direction <= `STWP_RST_PORTA_DIR;
            wdt_top <= `STWP_RST_WDT_TOP;
            wdt_enable <= 1'b0;
        end else begin
            if (wr_cfg) begin
                timer_prescale_config <= wdata;
            end
            if (wr_fire && avs_address == `STWP_OFF_PORTA_DIR) begin
                port_a_direction <= wdata & `STWP_PORTA_DIR_MASK;
            end
            if (wr_fire && avs_address == `STWP_OFF_WDT_TOP) begin
                wdt_top <= wdata;
            end
            if (wr_cmd) begin
                wdt_enable <= wdata[`STWP_BIT_CMD_WDT_EN];
            end
        end
    end

    // ********************
    // tick sources
    // ********************
    logic [2:0] pin_sync;
    logic pin_edge;
    logic [15:0] wdt_osc_count;
    logic wdt_osc_tick;
    logic timer_src_tick;

    assign pin_edge = t0_edge_sel ? (pin_sync[2] && !pin_sync[1]) : (!pin_sync[2] && pin_sync[1]);
    assign timer_src_tick = t0_src_pin ? pin_edge : 1'b1;
    assign wdt_osc_tick = (wdt_osc_count == 16'(WDT_TICK_CYCLES - 1));

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_sync <= 3'h0;
            wdt_osc_count <= 16'h0000;
        end else begin
            pin_sync <= {pin_sync[1:0], tmr_pin};
            wdt_osc_count <= wdt_osc_tick ? 16'h0000 : wdt_osc_count + 16'h0001;
        end
    end

    // ********************
    // shared divider
    // ********************
    logic on_watchdog;
    logic div_in;
    logic div_out;
    logic div_clear;
    logic [3:0] div_log2;
    logic timer_tick;
    logic wdt_tick;

    assign on_watchdog = divider_assign_bit;
    assign div_in = on_watchdog ? wdt_osc_tick : timer_src_tick;
    assign div_clear = on_watchdog ? watchdog_clear_instr : wr_tmr;
    assign div_log2 = on_watchdog ? {1'b0, divide_ratio_field}
                                  : {1'b0, divide_ratio_field} + 4'h1;
    assign timer_tick = on_watchdog ? timer_src_tick : div_out;
    assign wdt_tick = on_watchdog ? div_out : wdt_osc_tick;

    stwp_divider #(
        .WIDTH(8)
    ) u_divider (
        .mclk(mclk),
        .resetn(resetn),
        .tick_in(div_in),
        .clear(div_clear),
        .log2_ratio(div_log2),
        .tick_out(div_out)
    );

    // ********************
    // timer and watchdog counters
    // ********************
    logic tmr_wrap;

    assign tmr_wrap = timer_tick && !wr_tmr && (timer_count_value == 8'hFF);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            timer_count_value <= 8'h00;
            interrupt_control <= `STWP_RST_INTR_CTRL;
            timer_overflow <= 1'b0;
        end else begin
            timer_overflow <= tmr_wrap;
            if (wr_tmr) begin
                timer_count_value <= wdata;
            end else if (timer_tick) begin
                timer_count_value <= timer_count_value + 8'h01;
            end
            if (wr_fire && avs_address == `STWP_OFF_INTR_CTRL) begin
                interrupt_control <= wdata;
            end
            if (tmr_wrap) begin
                interrupt_control[`STWP_BIT_T0_IF] <= 1'b1;
            end
        end
    end

    logic wdt_expire;

    assign wdt_expire = wdt_enable && wdt_tick && !watchdog_clear_instr && (wdt_count == wdt_top);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wdt_count <= 8'h00;
            watchdog_reset <= 1'b0;
            wdt_timeout_seen <= 1'b0;
        end else begin
            watchdog_reset <= wdt_expire;
            if (watchdog_clear_instr || !wdt_enable || wdt_expire) begin
                wdt_count <= 8'h00;
            end else if (wdt_tick) begin
                wdt_count <= wdt_count + 8'h01;
            end
            if (wdt_expire) begin
                wdt_timeout_seen <= 1'b1;
            end else if (wr_fire && avs_address == `STWP_OFF_STATUS) begin
                wdt_timeout_seen <= 1'b0;
            end
        end
    end
endmodule

//--- tb/stwp_monitor.sv
/*
 * port assertions of the shared divider block.
 * assumes binding into stwp_top, one clock domain.
 */
module stwp_monitor #(
    parameter int WDT_TICK_CYCLES = 360
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pins and events
    input wire logic tmr_pin,
    input wire logic watchdog_reset,
    input wire logic timer_overflow
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire logic hit = avs_address inside {8'h01, 8'h0B, 8'h81, 8'h85, 8'h90, 8'h91, 8'h92};
    sequence s_rd_taken;
        avs_read && !avs_waitrequest;
    endsequence
    property p_wait_first;
        $rose(avs_read || avs_write) |-> avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait state");
    property p_wait_ans;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("late answer");
    property p_rd_upper;
        s_rd_taken |-> avs_readdata[31:8] == 24'h000000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_unmapped;
        s_rd_taken and !hit |-> avs_readdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_dir_mask;
        s_rd_taken and avs_address == 8'h85 |-> avs_readdata[7:5] == 3'h0;
    endproperty
    a_dir_mask: assert property (p_dir_mask) else $error("direction bits 7:5 set");
    property p_rd_stand;
        s_rd_taken ##1 !avs_read |-> $stable(avs_readdata);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
    property p_ovf_gap;
        timer_overflow |=> !timer_overflow [*8];
    endproperty
    a_ovf_gap: assert property (p_ovf_gap) else $error("overflow too soon");
    property p_wd_gap;
        watchdog_reset |=> !watchdog_reset [*3];
    endproperty
    a_wd_gap: assert property (p_wd_gap) else $error("watchdog too soon");
endmodule

bind stwp_top stwp_monitor #(.WDT_TICK_CYCLES(WDT_TICK_CYCLES)) u_stwp_monitor (
    .mclk(mclk),
    .resetn(resetn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .tmr_pin(tmr_pin),
    .watchdog_reset(watchdog_reset),
    .timer_overflow(timer_overflow)
);

//--- tb/tb.sv
/*
 * self-checking bench of stwp_top.
 * assumes the design files and the monitor compiled first.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
    logic mclk, resetn, avs_read, avs_write, avs_waitrequest;
    logic tmr_pin, pin_run, watchdog_reset, timer_overflow;
    logic [7:0] avs_address, v;
    logic [31:0] avs_writedata, avs_readdata, e;
    logic [31:0] expq[$];
    int mismatches, n_compared;
    stwp_top #(.WDT_TICK_CYCLES(4)) u_stwp_top (
        .mclk(mclk),
        .resetn(resetn),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .tmr_pin(tmr_pin),
        .watchdog_reset(watchdog_reset),
        .timer_overflow(timer_overflow)
    );
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // pin clock, and read results against the oldest note
    always @(posedge mclk) begin
        tmr_pin <= pin_run ? !tmr_pin : 1'b0;
        if (avs_read && !avs_waitrequest) begin
            e = expq.pop_front();
            `CHK(avs_readdata, e)
        end
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        expq.push_back({24'h000000, x});
        acc(1'b0, a, 8'h00);
    endtask
    task automatic wait_ev(input bit wd);
        do @(posedge mclk); while (!(wd ? watchdog_reset : timer_overflow));
    endtask
    // cycles between pulses, skipping the settling one
    task automatic per(input bit wd, input int n);
        time t0;
        repeat (2) wait_ev(wd);
        t0 = $time;
        wait_ev(wd);
        `CHK(($time - t0) / 50, n)
    endtask
    task automatic clrw;
        wr(8'h90, 8'h03);
    endtask
    task automatic to_tmr(input logic [7:0] c);
        clrw();
        wr(8'h81, c);
    endtask
    task automatic to_wdt(input logic [7:0] c);
        clrw();
        wr(8'h01, 8'h00);
        if (c[2:1] == 2'b00) begin
            wr(8'h81, 8'h2F);
            clrw();
        end
        wr(8'h81, c);
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ****************
    // stimulus
    // ****************
    initial begin
        {avs_read, avs_write, pin_run, resetn} = 4'h0;
        avs_address = 8'h00;
        avs_writedata = 32'h00000000;
        mismatches = 0;
        n_compared = 0;
        v = 8'($urandom(83386));
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        rd(8'h81, 8'hFF);
        rd(8'h85, 8'h1F);
        rd(8'h0B, 8'h00);
        rd(8'h01, 8'h00);
        wr(8'h85, 8'hFF);
        rd(8'h85, 8'h1F);
        wr(8'h02, v);
        rd(8'h02, 8'h00);
        v = 8'($urandom);
        to_tmr(8'h07);
        repeat (4) begin
            wr(8'h01, v);
            repeat (200) @(posedge mclk);
        end
        rd(8'h01, v);
        for (int r = 0; r < 2; r++) begin
            wr(8'h81, 8'(r));
            per(1'b0, 512 << r);
        end
        rd(8'h0B, 8'h04);
        pin_run <= 1'b1;
        to_wdt(8'h2F);
        per(1'b0, 512);
        pin_run <= 1'b0;
        wr(8'h92, 8'h01);
        clrw();
        wr(8'h81, 8'h08);
        per(1'b1, 8);
        rd(8'h90, 8'h02);
        rd(8'h92, 8'h01);
        wr(8'h81, 8'h0A);
        per(1'b1, 32);
        to_tmr(8'h07);
        per(1'b1, 8);
        to_wdt(8'h0F);
        wr(8'h92, 8'h00);
        clrw();
        rd(8'h91, 8'h01);
        wr(8'h91, 8'h00);
        repeat (3) begin
            repeat (300) @(posedge mclk);
            clrw();
        end
        rd(8'h91, 8'h00);
        test_done();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        test_done();
    end
endmodule
